// ==== rtc_countdown_timer_flags.sv ====
// Countdown timer with interrupt flags, reached over a serial register link.
// Assumes the link pins are asynchronous to mclk and are sampled here; tick
// and alarm event inputs come from logic on mclk as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_defs.svh"

//Function
// - Eight-bit down-counter steered by timer control
// - Two-bit select picks one of four sources
// - Zero halts; one to 255 are periods
// - At one set flag, reload, continue
// - Reading count returns the live counter
// - Mid-period write applies immediately, reloads later
// - First period carries bounded start uncertainty
// - Interrupt pin driven from flag when enabled
// - Pulse or level mode; separate enable
// - Countdown flag cleared only by software
// - Tick and countdown flags set, held
// - Flag writes are ANDed with present value
// - Flags at bits five, three, two
// - Alarm flag clears by the same AND
// - Enable bit seven, select bits one:zero
// - Bit four pulse mode, bit zero enable
// - Clearing flag ends interrupt pulse early
module rtc_countdown_timer_flags #(
  parameter int BASE_DIV = `BASE_TICK_DIV
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_ce,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic second_tick,
  input wire logic minute_tick,
  input wire logic alarm_event,
  output logic int_n_o,
  output logic int_n_oe
);
  import rtc_timer_pkg::*;

  core_state_t q; // Registered state
  core_state_t d; // Next state
  logic en8192; // Base tick for pulse widths
  logic en4096; // 4096 Hz source tick
  logic en64; // 64 Hz tick
  logic en1; // 1 Hz tick
  logic en_min; // Once-per-minute tick

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register read mux; reserved bits read as zero
  function automatic logic [7:0] reg_read(input logic [4:0] a, input core_state_t s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `ADDR_TIMER_CONTROL: begin
        r[`TC_TIMER_ON_BIT] = s.timer_on;
        r[1:0] = s.clk_sel;
      end
      `ADDR_COUNTDOWN_VALUE: begin
        r = s.count;
      end
      `ADDR_INT_CTRL_STATUS: begin
        r = {s.minute_tick_enable, s.second_tick_enable, s.tick_flag, s.irq_pulse_select,
             s.alarm_flag, s.countdown_flag, s.alarm_irq_enable, s.countdown_irq_enable};
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction : reg_read

  // Countdown interrupt pulse width in base ticks
  function automatic logic [7:0] cd_width(input src_sel_t sel, input logic [7:0] n);
    logic [7:0] w;
    w = `PW_SLOW;
    case (sel)
      SRC_4096HZ: w = (n == 8'h01) ? `PW_FAST_N1 : `PW_FAST;
      SRC_64HZ: w = (n == 8'h01) ? `PW_MID_N1 : `PW_SLOW;
      default: w = `PW_SLOW;
    endcase
    return w;
  endfunction : cd_width

  // ----------------------------------------------------------------
  // Rate enables
  // ----------------------------------------------------------------
  rtc_timer_prescale #(
    .BASE_DIV(BASE_DIV)
  ) u_presc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .en8192(en8192),
    .en4096(en4096),
    .en64(en64),
    .en1(en1),
    .en_min(en_min)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Link decode, register writes, counter, flags and interrupt pin
  always_comb begin
    logic rise;
    logic fall;
    logic [7:0] shv;
    logic wr;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic src_tick;
    logic fast;
    logic cd_event;
    logic tk_event;
    logic wr_ics;
    logic cd_lvl;
    logic tk_lvl;
    rise = 1'b0;
    fall = 1'b0;
    shv = 8'h00;
    wr = 1'b0;
    waddr = 5'h00;
    wdata = 8'h00;
    src_tick = 1'b0;
    fast = 1'b0;
    cd_event = 1'b0;
    tk_event = 1'b0;
    wr_ics = 1'b0;
    cd_lvl = 1'b0;
    tk_lvl = 1'b0;
    d = q;
    // Two-flop synchronisers on the link pins
    d.sclk_s = {q.sclk_s[0], spi_sclk};
    d.sdi_s = {q.sdi_s[0], spi_sdi};
    d.ce_s = {q.ce_s[0], spi_ce};
    d.sclk_prev = q.sclk_s[1];
    rise = q.sclk_s[1] & ~q.sclk_prev;
    fall = ~q.sclk_s[1] & q.sclk_prev;
    // Serial link: command byte, then data bytes with auto-increment
    if (!q.ce_s[1]) begin
      d.bitcnt = 3'h0;
      d.phase = PH_CMD;
    end else if (rise) begin
      shv = {q.sh_in[6:0], q.sdi_s[1]};
      d.sh_in = shv;
      if (q.bitcnt == 3'h7) begin
        d.bitcnt = 3'h0;
        if (q.phase == PH_CMD) begin
          d.rd = shv[`CMD_READ_BIT];
          d.addr = shv[4:0];
          d.phase = PH_DATA;
          if (shv[`CMD_READ_BIT]) begin
            d.sh_out = reg_read(shv[4:0], q);
          end
        end else begin
          if (!q.rd) begin
            wr = 1'b1;
            waddr = q.addr;
            wdata = shv;
          end
          d.addr = 5'(q.addr + 5'h01);
          if (q.rd) begin
            d.sh_out = reg_read(5'(q.addr + 5'h01), q);
          end
        end
      end else begin
        d.bitcnt = 3'(q.bitcnt + 3'h1);
      end
    end else if (fall && q.phase == PH_DATA && q.rd) begin
      // Shift out on the falling edge so the host samples on the rising one
      d.sdo = q.sh_out[7];
      d.sh_out = {q.sh_out[6:0], 1'b0};
    end
    // Source clock selection
    case (q.clk_sel)
      SRC_4096HZ: src_tick = en4096;
      SRC_64HZ: src_tick = en64;
      SRC_1HZ: src_tick = en1;
      SRC_MINUTE: src_tick = en_min;
      default: src_tick = 1'b0;
    endcase
    fast = (q.clk_sel == SRC_4096HZ) || (q.clk_sel == SRC_64HZ);
    // Down-counter with automatic reload; zero halts
    if (q.timer_on && q.reload != 8'h00) begin
      if (q.arm) begin
        // First period: fast sources skip a partial tick, slow ones align to 64 Hz
        if (fast ? src_tick : en64) begin
          d.arm = 1'b0;
        end
      end else if (src_tick) begin
        if (q.count <= 8'h01) begin
          cd_event = 1'b1;
          d.count = q.reload;
        end else begin
          d.count = 8'(q.count - 8'h01);
        end
      end
    end
    // Register writes
    wr_ics = wr && (waddr == `ADDR_INT_CTRL_STATUS);
    if (wr && waddr == `ADDR_TIMER_CONTROL) begin
      d.timer_on = wdata[`TC_TIMER_ON_BIT];
      d.clk_sel = src_sel_t'(wdata[1:0]);
      if (wdata[`TC_TIMER_ON_BIT] && !q.timer_on) begin
        d.count = q.reload;
        d.arm = 1'b1;
      end
    end
    if (wr && waddr == `ADDR_COUNTDOWN_VALUE) begin
      d.reload = wdata;
      d.count = wdata;
    end
    if (wr_ics) begin
      d.minute_tick_enable = wdata[`ICS_MINUTE_EN_BIT];
      d.second_tick_enable = wdata[`ICS_SECOND_EN_BIT];
      d.irq_pulse_select = wdata[`ICS_PULSE_SEL_BIT];
      d.alarm_irq_enable = wdata[`ICS_ALARM_IRQ_EN_BIT];
      d.countdown_irq_enable = wdata[`ICS_CD_IRQ_EN_BIT];
    end
    // Sticky flags: write-AND clear, a set in the same cycle wins
    tk_event = (q.minute_tick_enable & minute_tick) | (q.second_tick_enable & second_tick);
    d.countdown_flag = (q.countdown_flag & ~(wr_ics & ~wdata[`ICS_CD_FLAG_BIT])) | cd_event;
    d.tick_flag = (q.tick_flag & ~(wr_ics & ~wdata[`ICS_TICK_FLAG_BIT])) | tk_event;
    d.alarm_flag = (q.alarm_flag & ~(wr_ics & ~wdata[`ICS_ALARM_FLAG_BIT])) | alarm_event;
    // Countdown interrupt pulse
    if (cd_event) begin
      d.cd_pw = cd_width(q.clk_sel, q.reload);
    end else if (en8192 && q.cd_pw != 8'h00) begin
      d.cd_pw = 8'(q.cd_pw - 8'h01);
    end
    if (!d.countdown_flag) begin
      d.cd_pw = 8'h00;
    end
    // Minute/second interrupt pulse of 1/64 s
    if (tk_event) begin
      d.tk_pw = `PW_SLOW;
    end else if (en8192 && q.tk_pw != 8'h00) begin
      d.tk_pw = 8'(q.tk_pw - 8'h01);
    end
    if (!d.tick_flag) begin
      d.tk_pw = 8'h00;
    end
    // Interrupt pin: pulse or level, sources wire-ORed
    cd_lvl = d.irq_pulse_select ? (d.cd_pw != 8'h00) : d.countdown_flag;
    tk_lvl = d.irq_pulse_select ? (d.tk_pw != 8'h00) : d.tick_flag;
    d.int_act = (d.countdown_irq_enable & cd_lvl) | tk_lvl | (d.alarm_irq_enable & d.alarm_flag);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset to documented defaults
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.phase <= PH_CMD;
      q.timer_on <= 1'(`TIMER_CONTROL_RST >> `TC_TIMER_ON_BIT);
      q.clk_sel <= src_sel_t'(2'(`TIMER_CONTROL_RST));
      q.reload <= `COUNTDOWN_VALUE_RST;
      q.count <= `COUNTDOWN_VALUE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign spi_sdo = q.sdo;
  assign spi_sdo_oe = q.ce_s[1] & (q.phase == PH_DATA) & q.rd;
  assign int_n_o = 1'b0;
  assign int_n_oe = q.int_act;

endmodule : rtc_countdown_timer_flags
`default_nettype wire

// ==== rtc_timer_defs.svh ====
// Offsets, field positions, reset values and timing counts of the countdown timer.
// Assumes inclusion by bare name from the package and the modules.
`ifndef RTC_TIMER_DEFS_SVH
`define RTC_TIMER_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses on the serial link
// ----------------------------------------------------------------
`define ADDR_INT_CTRL_STATUS 5'h01
`define ADDR_TIMER_CONTROL 5'h0E
`define ADDR_COUNTDOWN_VALUE 5'h0F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TC_TIMER_ON_BIT 7
`define ICS_MINUTE_EN_BIT 7
`define ICS_SECOND_EN_BIT 6
`define ICS_TICK_FLAG_BIT 5
`define ICS_PULSE_SEL_BIT 4
`define ICS_ALARM_FLAG_BIT 3
`define ICS_CD_FLAG_BIT 2
`define ICS_ALARM_IRQ_EN_BIT 1
`define ICS_CD_IRQ_EN_BIT 0
`define CMD_READ_BIT 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TIMER_CONTROL_RST 8'h03
`define COUNTDOWN_VALUE_RST 8'h00
`define INT_CTRL_STATUS_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_HZ 10000000
`define BASE_TICK_HZ 8192
`define BASE_TICK_DIV (`MCLK_HZ / `BASE_TICK_HZ)
`define PRESC_STAGE 64
`define SECONDS_PER_MINUTE 60
// Interrupt pulse widths in base ticks of 1/8192 s
`define PW_FAST_N1 8'h01
`define PW_FAST 8'h02
`define PW_MID_N1 8'h40
`define PW_SLOW 8'h80

`endif

// ==== rtc_timer_flags_sva.sv ====
// Checker for the countdown timer's serial read path and interrupt pin.
// Assumes it is bound to the timer top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module rtc_timer_flags_sva (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_ce,
  input wire logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  input wire logic int_n_o,
  input wire logic int_n_oe
);
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic sclk_q; // Last link clock level
  logic [3:0] rises_q; // Link clock rises in this frame
  logic rd_q; // First bit of the frame: read command

  // Count rises and keep the direction bit of each frame
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      rises_q <= 4'h0;
      rd_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
      if (!spi_ce) rises_q <= 4'h0;
      else if (spi_sclk && !sclk_q && rises_q != 4'hF) rises_q <= rises_q + 4'h1;
      if (spi_ce && spi_sclk && !sclk_q && rises_q == 4'h0) rd_q <= spi_sdi;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_INT_DATA_LOW: assert property (@(posedge mclk) disable iff (sys_rst) int_n_o == 1'b0)
    else $error("interrupt pin data not low");
  AST_RESET_QUIET: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> !int_n_oe && !spi_sdo_oe)
    else $error("outputs active after reset");
  AST_SDO_STABLE_HIGH: assert property (@(posedge mclk) disable iff (sys_rst)
    spi_sclk && $past(spi_sclk) && $past(spi_sclk, 2) |-> $stable(spi_sdo))
    else $error("read data moved while link clock high");
  // Drive starts about three mclk after the command's last rise on the link clock pin
  AST_OE_RISE_ON_HIGH: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(spi_sdo_oe) |-> $past(spi_sclk, 3) && $past(spi_sclk, 2))
    else $error("data drive began outside the last command high phase");
  AST_OE_RISE_IN_FRAME: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(spi_sdo_oe) |-> spi_ce && $past(spi_ce, 3))
    else $error("data drive began outside a frame");
  AST_OE_DROP_AT_CE: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(spi_sdo_oe) |-> !(spi_ce && $past(spi_ce) && $past(spi_ce, 2) && $past(spi_ce, 3)))
    else $error("data drive dropped inside a frame");
  AST_OE_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
    !spi_ce [*6] |-> !spi_sdo_oe)
    else $error("data driven while deselected");
  AST_OE_AFTER_CMD: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(spi_sdo_oe) |-> rises_q >= 4'h8)
    else $error("data drive before the command byte ended");
  AST_WRITE_NO_DRIVE: assert property (@(posedge mclk) disable iff (sys_rst)
    spi_sdo_oe |-> rd_q)
    else $error("data driven during a write frame");
endmodule : rtc_timer_flags_sva

bind rtc_countdown_timer_flags rtc_timer_flags_sva rtc_timer_flags_sva_inst (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .spi_sclk(spi_sclk),
  .spi_ce(spi_ce),
  .spi_sdi(spi_sdi),
  .spi_sdo(spi_sdo),
  .spi_sdo_oe(spi_sdo_oe),
  .int_n_o(int_n_o),
  .int_n_oe(int_n_oe)
);

`default_nettype wire

// ==== rtc_timer_pkg.sv ====
// Types shared by the countdown timer and its prescaler.
// Assumes the defines header is on the include path.
`include "rtc_timer_defs.svh"

package rtc_timer_pkg;

  // ----------------------------------------------------------------
  // Source clock choice
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_4096HZ = 2'b00,
    SRC_64HZ = 2'b01,
    SRC_1HZ = 2'b10,
    SRC_MINUTE = 2'b11
  } src_sel_t;

  // ----------------------------------------------------------------
  // Serial transfer phase
  // ----------------------------------------------------------------
  typedef enum logic {
    PH_CMD = 1'b0,
    PH_DATA = 1'b1
  } spi_phase_t;

  // All state of the timer core
  typedef struct packed {
    logic [1:0] sclk_s;
    logic sclk_prev;
    logic [1:0] sdi_s;
    logic [1:0] ce_s;
    logic [2:0] bitcnt;
    spi_phase_t phase;
    logic rd;
    logic [4:0] addr;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic sdo;
    logic timer_on;
    src_sel_t clk_sel;
    logic [7:0] reload;
    logic [7:0] count;
    logic arm;
    logic minute_tick_enable;
    logic second_tick_enable;
    logic irq_pulse_select;
    logic alarm_irq_enable;
    logic countdown_irq_enable;
    logic tick_flag;
    logic alarm_flag;
    logic countdown_flag;
    logic [7:0] cd_pw;
    logic [7:0] tk_pw;
    logic int_act;
  } core_state_t;

  // All state of the prescaler
  typedef struct packed {
    logic [15:0] div;
    logic half;
    logic [5:0] c64;
    logic [5:0] c1;
    logic [5:0] c60;
    logic en8192;
    logic en4096;
    logic en64;
    logic en1;
    logic en_min;
  } presc_state_t;

endpackage : rtc_timer_pkg

// ==== rtc_timer_prescale.sv ====
// Prescaler: one-cycle enables at 8192 Hz, 4096 Hz, 64 Hz, 1 Hz and one per minute.
// Assumes a single free-running mclk; the base rate is an integer approximation.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_defs.svh"

module rtc_timer_prescale #(
  parameter int BASE_DIV = `BASE_TICK_DIV
) (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic en8192,
  output logic en4096,
  output logic en64,
  output logic en1,
  output logic en_min
);
  import rtc_timer_pkg::*;

  presc_state_t q; // Registered state
  presc_state_t d; // Next state

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  // Each stage advances on the enable of the stage below
  always_comb begin
    d = q;
    d.en8192 = (q.div == 16'(BASE_DIV - 1));
    d.div = d.en8192 ? 16'h0000 : 16'(q.div + 16'h0001);
    d.en4096 = d.en8192 & q.half;
    if (d.en8192) begin
      d.half = ~q.half;
    end
    d.en64 = d.en4096 & (q.c64 == 6'(`PRESC_STAGE - 1));
    if (d.en4096) begin
      d.c64 = 6'(q.c64 + 6'h01);
    end
    d.en1 = d.en64 & (q.c1 == 6'(`PRESC_STAGE - 1));
    if (d.en64) begin
      d.c1 = 6'(q.c1 + 6'h01);
    end
    d.en_min = d.en1 & (q.c60 == 6'(`SECONDS_PER_MINUTE - 1));
    if (d.en1) begin
      d.c60 = d.en_min ? 6'h00 : 6'(q.c60 + 6'h01);
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign en8192 = q.en8192;
  assign en4096 = q.en4096;
  assign en64 = q.en64;
  assign en1 = q.en1;
  assign en_min = q.en_min;

endmodule : rtc_timer_prescale
`default_nettype wire

// ==== spi_host_model.sv ====
// Host model: link master sending one command byte and one data byte per frame.
// Assumes mode 0, link clock made from mclk, idle low outside frames.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  input wire logic mclk,
  output logic spi_sclk,
  output logic spi_ce,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  // Idle lines at time zero
  initial begin
    spi_sclk = 1'b0;
    spi_ce = 1'b0;
    spi_sdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame, MSB first; hp is the half period in mclk (4 or more)
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int hp, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(posedge mclk);
    spi_ce <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= sh[i];
      repeat (hp) @(posedge mclk);
      spi_sclk <= 1'b1;
      // Sample on the rise; undriven data reads as 0
      if (i < 8) rd[i] = spi_sdo & spi_sdo_oe;
      repeat (hp) @(posedge mclk);
      spi_sclk <= 1'b0;
    end
    repeat (hp) @(posedge mclk);
    spi_ce <= 1'b0;
    spi_sdi <= ~spi_sdi; // Released line shows the inverse
    repeat (4) @(posedge mclk);
  endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the countdown timer with flags.
// Assumes BASE_DIV of 4: one 4096 Hz tick every 8 mclk.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rtc_timer_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic second_tick = 1'b0;
  logic minute_tick = 1'b0;
  logic alarm_event = 1'b0;
  logic spi_sclk, spi_ce, spi_sdi, spi_sdo, spi_sdo_oe, int_n_o, int_n_oe;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] rd, rd2, n;
  int c, w;

  always #50 mclk = ~mclk;

  rtc_countdown_timer_flags #(.BASE_DIV(4)) rtc_countdown_timer_flags_inst (.mclk(mclk), .sys_rst(sys_rst),
    .spi_sclk(spi_sclk), .spi_ce(spi_ce), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .second_tick(second_tick), .minute_tick(minute_tick), .alarm_event(alarm_event),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe));
  spi_host_model spi_host_model_inst (.mclk(mclk), .spi_sclk(spi_sclk), .spi_ce(spi_ce),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi_host_model_inst.xfer({3'b000, a}, d, 4 + $urandom_range(2), x);
  endtask : wr

  task automatic rdr(input logic [4:0] a, output logic [7:0] d);
    spi_host_model_inst.xfer({3'b100, a}, 8'h00, 4 + $urandom_range(2), d);
  endtask : rdr

  task automatic check_eq(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_eq

  task automatic check_rng(input string what, input int lo, input int hi, input logic [15:0] got);
    compares++;
    // Signed compare so a negative lower bound works; unknowns still fail
    if (($signed({16'h0000, got}) >= lo && $signed({16'h0000, got}) <= hi) !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng

  // Cycles until the interrupt pin reaches a level
  task automatic edge_to(input logic lvl, output int cyc);
    cyc = 0;
    while (int_n_oe !== lvl && cyc < 5000) begin
      @(posedge mclk);
      cyc++;
    end
  endtask : edge_to

  // One-cycle event pulse: {minute, second, alarm}
  task automatic ev(input logic [2:0] m);
    @(posedge mclk);
    {minute_tick, second_tick, alarm_event} <= m;
    @(posedge mclk);
    {minute_tick, second_tick, alarm_event} <= 3'b000;
    repeat (3) @(posedge mclk);
  endtask : ev

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(7));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // Reset values and an unmapped place
    rdr(5'h0E, rd); check_eq("timer_control", 8'h03, rd);
    rdr(5'h0F, rd); check_eq("countdown_value", 8'h00, rd);
    rdr(5'h01, rd); check_eq("interrupt_control_status", 8'h00, rd);
    rdr(5'h05, rd); check_eq("unmapped", 8'h00, rd);
    // Every source select, reserved bits random; ends parked at the slowest
    for (int s = 0; s < 4; s++) begin
      wr(5'h0E, {1'b0, 5'($urandom), 2'(s)});
      rdr(5'h0E, rd); check_eq("timer_control", {6'h00, 2'(s)}, rd);
    end
    // Pulse mode with countdown interrupt on
    wr(5'h01, 8'h11);
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 8'h01 : (k == 1) ? 8'hFF : 8'(3 + $urandom_range(20));
      wr(5'h0E, {6'h00, SRC_4096HZ});
      wr(5'h0F, n);
      wr(5'h0E, {1'b1, 5'h00, SRC_4096HZ});
      edge_to(1'b1, c); check_rng("first period", 8 * n - 24, 8 * n + 12, 16'(c));
      // The first pulse may already be under way when the write returns
      edge_to(1'b0, w); edge_to(1'b1, c);
      edge_to(1'b0, w); check_rng("pulse width", (n == 1) ? 2 : 4, (n == 1) ? 4 : 8, 16'(w));
      edge_to(1'b1, c); check_eq("period", 8'(8 * n / 8), 8'((w + c) / 8));
      check_rng("period low bits", 0, 0, 16'((w + c) % 8));
      rdr(5'h0F, rd); rdr(5'h0F, rd2);
      check_rng("live count", 1, n, {8'h00, rd});
      check_rng("live count", 1, n, {8'h00, rd2});
    end
    // New count while running: later periods use it
    wr(5'h0F, 8'h04);
    edge_to(1'b0, c); edge_to(1'b1, c);
    edge_to(1'b0, w); edge_to(1'b1, c); check_rng("new period", 32, 32, 16'(w + c));
    // Stop and park; the flag stays until software clears it
    wr(5'h0E, 8'h03);
    repeat (64) @(posedge mclk);
    rdr(5'h01, rd); check_eq("flag held", 8'h15, rd);
    wr(5'h01, 8'h11);
    rdr(5'h01, rd); check_eq("flag cleared", 8'h11, rd);
    // 64 Hz source: first period, then a flag clear cuts the long pulse short
    wr(5'h0F, 8'h02);
    wr(5'h0E, {1'b1, 5'h00, SRC_64HZ});
    edge_to(1'b1, c); check_rng("first period 64 Hz", 1000, 1548, 16'(c));
    wr(5'h01, 8'h11);
    check_eq("pulse cut", 8'h00, {7'h00, int_n_oe});
    wr(5'h0E, 8'h03);
    // Zero count halts the timer
    wr(5'h0F, 8'h00);
    wr(5'h0E, {1'b1, 5'h00, SRC_4096HZ});
    repeat (200) @(posedge mclk);
    rdr(5'h01, rd); check_eq("no flag at zero", 8'h11, rd);
    check_eq("pin idle", 8'h00, {7'h00, int_n_oe});
    wr(5'h0E, 8'h03);
    // Tick and alarm flags, level mode, alarm interrupt on
    wr(5'h01, 8'h42);
    ev(3'b100);
    rdr(5'h01, rd); check_eq("minute tick disabled", 8'h42, rd);
    ev(3'b010);
    ev(3'b001);
    rdr(5'h01, rd); check_eq("flags set", 8'h6A, rd);
    check_eq("alarm pin", 8'h01, {7'h00, int_n_oe});
    wr(5'h01, 8'h4A);
    rdr(5'h01, rd); check_eq("tick cleared", 8'h4A, rd);
    check_eq("alarm pin alone", 8'h01, {7'h00, int_n_oe});
    wr(5'h01, 8'h62);
    rdr(5'h01, rd); check_eq("alarm cleared", 8'h42, rd);
    check_eq("alarm pin", 8'h00, {7'h00, int_n_oe});
    summarize();
  end
endmodule : testbench

`default_nettype wire
